// >>> logic/ssp_device.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_device (
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    input  wire logic       i_clock_en,
    input  wire logic       i_port_enable,
    input  wire logic       i_spi_mode,
    input  wire logic       i_clock_polarity_sel,
    input  wire logic       i_status_wr,
    input  wire logic [7:0] i_status_wdata,
    input  wire logic       i_addr_wr,
    input  wire logic [7:0] i_addr_wdata,
    input  wire logic       i_tx_wr,
    input  wire logic [7:0] i_tx_data,
    output logic [7:0]      o_status,
    output logic [7:0]      o_slave_address,
    output logic            o_rx_valid,
    input  wire logic       i_rx_ready,
    output logic [7:0]      o_rx_data,
    ssp_link_if.device      link
);
    typedef enum logic [1:0] {L_IDLE, L_ADDR, L_RX, L_TX} ssp_lstate_t;
    localparam int unsigned CFG_W = 13;

    // ---------------- register side, i_clock ----------------
    logic       sample_phase_sel;
    logic       edge_sel;
    logic [7:0] slave_address_reg;
    logic [7:0] tx_data;
    logic       tx_pend;
    logic       address_update_flag;
    logic [3:0] st_a, st_s;
    logic [2:0] tg_a, tg_s;
    logic       ack_t, taken_seen, ua_seen;
    logic       rx_in_ready;

    // Link-side registers; the flags, toggles and rx_hold are read across the crossing
    ssp_lstate_t state;
    logic [3:0]  cnt;
    logic [7:0]  sr, txsr, rx_hold;
    logic        s_flag, p_flag, rw, da, m_ack, sda_oe, miso;
    logic        req_t, ua_t, taken_t;

    wire rx_push   = (tg_s[0] != ack_t) && rx_in_ready;
    wire taken_evt = (tg_s[1] != taken_seen);
    wire ua_evt    = (tg_s[2] != ua_seen);
    wire [CFG_W-1:0] cfg_src = {i_clock_en, i_port_enable, i_spi_mode,
        i_clock_polarity_sel, sample_phase_sel, edge_sel,
        slave_address_reg[7:1]};

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            {st_s, st_a} <= '0;
            {tg_s, tg_a} <= '0;
        end
        else if (i_clock_en)
        begin
            st_a <= {s_flag, p_flag, rw, da};
            st_s <= st_a;
            tg_a <= {ua_t, taken_t, req_t};
            tg_s <= tg_a;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sample_phase_sel <= ssp_pkg::STATUS_RESET[ssp_pkg::SAMPLE_PHASE_BIT];
            edge_sel         <= ssp_pkg::STATUS_RESET[ssp_pkg::EDGE_SEL_BIT];
            slave_address_reg   <= ssp_pkg::SLAVE_ADDRESS_RESET;
            tx_data             <= 8'h00;
            tx_pend             <= 1'b0;
            address_update_flag <= 1'b0;
            ack_t      <= 1'b0;
            taken_seen <= 1'b0;
            ua_seen    <= 1'b0;
        end
        else if (i_clock_en)
        begin
            if (i_status_wr)
            begin
                sample_phase_sel <= i_status_wdata[ssp_pkg::SAMPLE_PHASE_BIT];
                edge_sel         <= i_status_wdata[ssp_pkg::EDGE_SEL_BIT];
            end
            if (i_addr_wr)
                slave_address_reg <= i_addr_wdata;
            if (rx_push)
                ack_t <= ~ack_t;
            taken_seen <= tg_s[1];
            ua_seen    <= tg_s[2];
            // New match wins over a same-cycle address rewrite
            if (ua_evt)
                address_update_flag <= 1'b1;
            else if (i_addr_wr)
                address_update_flag <= 1'b0;
            // A byte written in the taking cycle stays pending
            if (i_tx_wr)
            begin
                tx_data <= i_tx_data;
                tx_pend <= 1'b1;
            end
            else if (taken_evt)
                tx_pend <= 1'b0;
        end
    end

    ssp_fifo2 #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
        .i_clock    (i_clock),
        .i_nrst     (i_nrst),
        .i_clock_en (i_clock_en),
        .i_in_valid (tg_s[0] != ack_t),
        .o_in_ready (rx_in_ready),
        .i_in_data  (rx_hold),
        .o_out_valid(o_rx_valid),
        .i_out_ready(i_rx_ready),
        .o_out_data (o_rx_data)
    );

    assign o_slave_address = slave_address_reg;
    assign o_status = {sample_phase_sel, edge_sel, st_s[0], st_s[2], st_s[3],
        st_s[1], address_update_flag, o_rx_valid | tx_pend};

    // ---------------- link side, link.link_clk ----------------
    logic             lrst_a, lrst_n;
    logic [CFG_W-1:0] cfg_a, cfg_l;
    logic [7:0]       txd_a, txd_l;
    logic             pend_a, pend_b, pend_l, ackr_a, ackr_l;
    logic [1:0]       pin_a, pin_l, pin_d;

    always_ff @(posedge link.link_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            {lrst_n, lrst_a} <= 2'b00;
        else
            {lrst_n, lrst_a} <= {lrst_a, 1'b1};
    end

    // Config and tx byte are held static while they are consumed
    always_ff @(posedge link.link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            {cfg_l, cfg_a} <= '0;
            {txd_l, txd_a} <= '0;
            {pend_l, pend_b, pend_a, ackr_l, ackr_a} <= '0;
        end
        else
        begin
            cfg_a <= cfg_src;
            cfg_l <= cfg_a;
            txd_a <= tx_data;
            txd_l <= txd_a;
            // Extra stage: pending is seen only after the data settled
            {pend_l, pend_b, pend_a} <= {pend_b, pend_a, tx_pend};
            {ackr_l, ackr_a} <= {ackr_a, ack_t};
        end
    end

    wire       l_en    = cfg_l[12];
    wire       en_l    = cfg_l[11];
    wire       spi_l   = cfg_l[10];
    wire       ckp_l   = cfg_l[9];
    wire       smp_l   = cfg_l[8];
    wire       edge_l  = cfg_l[7];
    wire [6:0] addr_l  = cfg_l[6:0];
    wire       scl_l   = pin_l[1];
    wire       sda_l   = pin_l[0];
    wire       rise    = scl_l & ~pin_d[1];
    wire       fall    = ~scl_l & pin_d[1];
    wire       start_c = scl_l & pin_d[1] & pin_d[0] & ~sda_l;
    wire       stop_c  = scl_l & pin_d[1] & ~pin_d[0] & sda_l;
    wire       out_r   = edge_l ^ ckp_l;
    wire       out_e   = out_r ? rise : fall;
    wire       in_e    = smp_l ? out_e : (out_r ? fall : rise);
    wire       busy    = (req_t != ackr_l);
    wire [7:0] tx_next = pend_l ? txd_l : ssp_pkg::IDLE_TX_BYTE;
    wire       i2c_ok  = en_l & ~spi_l & ~start_c & ~stop_c;
    wire       spi_ld  = en_l & spi_l & in_e & (cnt == ssp_pkg::LAST_DATA_BIT);
    wire       i2c_ld  = i2c_ok & fall & (cnt == ssp_pkg::ACK_SLOT)
                         & (((state == L_ADDR) & rw) | ((state == L_TX) & m_ack));
    wire       i2c_sh  = i2c_ok & fall & (state == L_TX)
                         & (cnt < ssp_pkg::LAST_DATA_BIT);
    wire       a_match = (sr[7:1] == addr_l);

    always_ff @(posedge link.link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            {pin_d, pin_l, pin_a} <= 6'h3F;
            txsr    <= ssp_pkg::IDLE_TX_BYTE;
            miso    <= 1'b1;
            taken_t <= 1'b0;
        end
        else if (l_en)
        begin
            pin_a <= {link.scl, link.sda};
            pin_l <= pin_a;
            pin_d <= pin_l;
            if (spi_ld || i2c_ld)
            begin
                txsr    <= (spi_ld && out_e) ? {tx_next[6:0], 1'b0} : tx_next;
                taken_t <= pend_l ? ~taken_t : taken_t;
                if (spi_ld && out_e)
                    miso <= tx_next[7];
            end
            else if (en_l && spi_l && out_e)
            begin
                miso <= txsr[7];
                txsr <= {txsr[6:0], 1'b0};
            end
            else if (i2c_sh)
                txsr <= {txsr[6:0], 1'b0};
        end
    end

    always_ff @(posedge link.link_clk or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state <= L_IDLE;
            cnt   <= 4'h0;
            {sr, rx_hold} <= '0;
            {s_flag, p_flag, rw, da, m_ack, sda_oe} <= '0;
            {req_t, ua_t} <= '0;
        end
        else if (l_en)
        begin
            if (!en_l)
            begin
                {s_flag, p_flag} <= 2'b00;
                state  <= L_IDLE;
                cnt    <= 4'h0;
                sda_oe <= 1'b0;
            end
            else if (spi_l)
            begin
                if (in_e)
                begin
                    sr  <= {sr[6:0], sda_l};
                    cnt <= spi_ld ? 4'h0 : cnt + 4'h1;
                    if (spi_ld && !busy)
                    begin
                        rx_hold <= {sr[6:0], sda_l};
                        req_t   <= ~req_t;
                        da      <= 1'b1;
                    end
                end
            end
            else if (start_c)
            begin
                {s_flag, p_flag, rw} <= 3'b100;
                state  <= L_ADDR;
                // The start's own clock fall wraps this to zero
                cnt    <= 4'hF;
                sda_oe <= 1'b0;
            end
            else if (stop_c)
            begin
                {s_flag, p_flag, rw} <= 3'b010;
                state  <= L_IDLE;
                sda_oe <= 1'b0;
            end
            else
            begin
                if (rise && cnt < ssp_pkg::ACK_SLOT)
                    sr <= {sr[6:0], sda_l};
                else if (rise && state == L_TX)
                    m_ack <= ~sda_l;
                if (fall)
                begin
                    cnt <= (cnt == ssp_pkg::ACK_SLOT) ? 4'h0 : cnt + 4'h1;
                    if (cnt == ssp_pkg::LAST_DATA_BIT)
                    begin
                        case (state)
                        L_ADDR:
                        begin
                            if (a_match)
                            begin
                                sda_oe <= 1'b1;
                                rw     <= sr[0];
                                da     <= 1'b0;
                                ua_t   <= ~ua_t;
                            end
                            else
                                state <= L_IDLE;
                        end
                        L_RX:
                        begin
                            da <= 1'b1;
                            // Full buffer: leave data high, a nack
                            if (!busy)
                            begin
                                rx_hold <= sr;
                                req_t   <= ~req_t;
                                sda_oe  <= 1'b1;
                            end
                        end
                        L_TX:
                        begin
                            sda_oe <= 1'b0;
                            da     <= 1'b1;
                        end
                        default:
                            sda_oe <= 1'b0;
                        endcase
                    end
                    else if (cnt == ssp_pkg::ACK_SLOT)
                    begin
                        if (i2c_ld)
                        begin
                            state  <= L_TX;
                            sda_oe <= ~tx_next[7];
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            if (state == L_ADDR)
                                state <= L_RX;
                            else if (state == L_TX)
                                state <= L_IDLE;
                        end
                    end
                    else if (i2c_sh)
                        sda_oe <= ~txsr[6];
                end
            end
        end
    end

    assign link.sda_d_out = 1'b0;
    assign link.sda_d_oe  = sda_oe;
    assign link.miso      = miso;
endmodule // ssp_device
`default_nettype wire

// >>> logic/ssp_pkg.sv
// Behaviour
// - SPI input sampled at end or middle.
// - Software keeps sample phase cleared as slave.
// - Edge select picks shifting clock edge.
// - Stop flag set on stop, cleared otherwise.
// - Start flag set on start, cleared otherwise.
// - Capture read/write bit of matching address.
// - Master keeps bus through repeated start.
// - Start is data falling while clock high.
// - Acknowledge holds data low, nack leaves high.
`default_nettype none
package ssp_pkg;
    localparam logic [7:0] SLAVE_ADDRESS_REG_OFFSET = 8'h93;
    localparam logic [7:0] SERIAL_PORT_STATUS_OFFSET = 8'h94;
    localparam logic [7:0] SLAVE_ADDRESS_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int unsigned SAMPLE_PHASE_BIT = 7;
    localparam int unsigned EDGE_SEL_BIT = 6;
    localparam int unsigned DATA_ADDR_BIT = 5;
    localparam int unsigned STOP_SEEN_BIT = 4;
    localparam int unsigned START_SEEN_BIT = 3;
    localparam int unsigned READ_WRITE_BIT = 2;
    localparam int unsigned ADDR_UPDATE_BIT = 1;
    localparam int unsigned BUFFER_FULL_BIT = 0;
    localparam logic [7:0] IDLE_TX_BYTE = 8'hFF;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned LINK_HALF_NS = 20;
    localparam int unsigned QUARTER_BIT_NS = 320;
    localparam int unsigned LINK_HALF_CYCLES = LINK_HALF_NS / CLOCK_PERIOD_NS;
    localparam int unsigned QUARTER_CYCLES = QUARTER_BIT_NS / CLOCK_PERIOD_NS;
    typedef enum logic [2:0] {
        CMD_START,
        CMD_STOP,
        CMD_WRITE,
        CMD_READ_ACK,
        CMD_READ_NACK,
        CMD_SPI
    } ssp_cmd_t;
endpackage
`default_nettype wire

// >>> logic/ssp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
    logic link_clk;
    logic scl_out;
    logic scl_oe;
    logic sda_m_out;
    logic sda_m_oe;
    logic sda_d_out;
    logic sda_d_oe;
    logic miso;
    wire  scl;
    wire  sda;

    // Pulled-up wires: a low from any enabled driver wins, else the wire is high
    assign scl = scl_oe ? scl_out : 1'b1;
    assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_d_oe ? sda_d_out : 1'b1);

    modport host (
        output link_clk, scl_out, scl_oe, sda_m_out, sda_m_oe,
        input  sda, miso
    );
    modport device (
        input  link_clk, scl, sda,
        output sda_d_out, sda_d_oe, miso
    );
endinterface
`default_nettype wire

// >>> logic/ssp_fifo2.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo2 #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             i_clock,
    input  wire logic             i_nrst,
    input  wire logic             i_clock_en,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (count != FULL);
    assign o_out_valid = (count != '0);
    assign o_out_data  = mem[rd_ptr];

    always_ff @(posedge i_clock)
    begin
        if (i_clock_en && push)
            mem[wr_ptr] <= i_in_data;
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else if (i_clock_en)
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            if (push != pop)
                count <= push ? count + 1'b1 : count - 1'b1;
        end
    end
endmodule // ssp_fifo2
`default_nettype wire

// >>> logic/ssp_host.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    input  wire logic              i_clock_en,
    input  wire logic              i_cmd_valid,
    input  wire ssp_pkg::ssp_cmd_t i_cmd,
    input  wire logic [7:0]        i_cmd_data,
    output logic                   o_cmd_ready,
    output logic                   o_rsp_valid,
    output logic [7:0]             o_rsp_data,
    output logic                   o_rsp_ack,
    ssp_link_if.host               link
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_STOP, H_BITS} ssp_hstate_t;

    ssp_hstate_t       state;
    ssp_pkg::ssp_cmd_t cmd_q;
    logic [7:0]        div_cnt, q_cnt, sr;
    logic [3:0]        bit_cnt;
    logic [1:0]        step, sda_s, miso_s;
    logic              link_clk_q, scl_oe, sda_oe;

    wire tick     = (q_cnt == 8'(ssp_pkg::QUARTER_CYCLES - 1));
    wire is_spi   = (cmd_q == ssp_pkg::CMD_SPI);
    wire is_read  = (cmd_q == ssp_pkg::CMD_READ_ACK)
                    || (cmd_q == ssp_pkg::CMD_READ_NACK);
    wire ack_slot = (bit_cnt == ssp_pkg::ACK_SLOT);
    wire last_bit = ack_slot || (is_spi && bit_cnt == ssp_pkg::LAST_DATA_BIT);
    // Ack slot: pull low only when acknowledging a read
    wire drive_lo = ack_slot ? (cmd_q == ssp_pkg::CMD_READ_ACK)
                             : (!is_read && !sr[7]);
    wire sample   = is_spi ? miso_s[1] : sda_s[1];

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            div_cnt    <= 8'h00;
            link_clk_q <= 1'b0;
            sda_s      <= 2'b11;
            miso_s     <= 2'b11;
        end
        else if (i_clock_en)
        begin
            sda_s  <= {sda_s[0], link.sda};
            miso_s <= {miso_s[0], link.miso};
            if (div_cnt == 8'(ssp_pkg::LINK_HALF_CYCLES - 1))
            begin
                div_cnt    <= 8'h00;
                link_clk_q <= ~link_clk_q;
            end
            else
                div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            state   <= H_IDLE;
            cmd_q   <= ssp_pkg::CMD_START;
            {q_cnt, sr} <= '0;
            bit_cnt <= 4'h0;
            step    <= 2'b00;
            {scl_oe, sda_oe} <= 2'b00;
            {o_rsp_valid, o_rsp_data, o_rsp_ack} <= '0;
        end
        else if (i_clock_en)
        begin
            o_rsp_valid <= 1'b0;
            q_cnt <= (state == H_IDLE || tick) ? 8'h00 : q_cnt + 8'h01;
            case (state)
            H_IDLE:
            begin
                if (i_cmd_valid)
                begin
                    cmd_q   <= i_cmd;
                    sr      <= i_cmd_data;
                    step    <= 2'b00;
                    bit_cnt <= 4'h0;
                    state   <= (i_cmd == ssp_pkg::CMD_START) ? H_START :
                               (i_cmd == ssp_pkg::CMD_STOP)  ? H_STOP : H_BITS;
                end
            end
            H_START:
            begin
                // From busy bus this is a repeated start after the ack
                if (tick)
                begin
                    step <= step + 2'b01;
                    case (step)
                    2'd0: sda_oe <= 1'b0;
                    2'd1: scl_oe <= 1'b0;
                    2'd2: sda_oe <= 1'b1;
                    default:
                    begin
                        scl_oe <= 1'b1;
                        state  <= H_IDLE;
                    end
                    endcase
                end
            end
            H_STOP:
            begin
                if (tick)
                begin
                    step <= step + 2'b01;
                    case (step)
                    2'd0: sda_oe <= 1'b1;
                    2'd1: scl_oe <= 1'b0;
                    2'd2: sda_oe <= 1'b0;
                    default: state <= H_IDLE;
                    endcase
                end
            end
            H_BITS:
            begin
                if (tick)
                begin
                    step <= step + 2'b01;
                    case (step)
                    2'd0:
                    begin
                        scl_oe <= 1'b1;
                        sda_oe <= drive_lo;
                    end
                    2'd1: scl_oe <= 1'b0;
                    2'd2:
                    begin
                        if (ack_slot)
                            o_rsp_ack <= ~sample;
                        else
                            sr <= {sr[6:0], sample};
                    end
                    default:
                    begin
                        scl_oe  <= 1'b1;
                        bit_cnt <= bit_cnt + 4'h1;
                        if (last_bit)
                        begin
                            if (is_read || is_spi)
                                sda_oe <= 1'b0;
                            o_rsp_valid <= 1'b1;
                            o_rsp_data  <= sr;
                            state       <= H_IDLE;
                        end
                    end
                    endcase
                end
            end
            default: state <= H_IDLE;
            endcase
        end
    end

    assign o_cmd_ready    = (state == H_IDLE);
    assign link.link_clk  = link_clk_q;
    assign link.scl_out   = 1'b0;
    assign link.scl_oe    = scl_oe;
    assign link.sda_m_out = 1'b0;
    assign link.sda_m_oe  = sda_oe;
endmodule // ssp_host
`default_nettype wire

// >>> logic/ssp_dummy_none.sv
`default_nettype none
`default_nettype wire

// >>> verification/ssp_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_chk (
    input wire logic link_clk,
    input wire logic i_nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic scl_oe,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe
);
    logic [1:0] armed;

    // First ticks after reset have no real history for $past
    always_ff @(posedge link_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            armed <= 2'b00;
        else
            armed <= {armed[0], 1'b1};
    end

    default clocking @(posedge link_clk); endclocking
    default disable iff (!i_nrst || !armed[1]);
    AST_SCL_OD: assert property (scl_oe |-> !scl)
        else $error("scl high while pulled");
    AST_HOST_OD: assert property (sda_m_oe |-> !sda)
        else $error("sda high while host pulls");
    AST_DEV_OD: assert property (sda_d_oe |-> !sda)
        else $error("sda high while device pulls");
    AST_DEV_EDGE: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device moved sda with scl high");
    AST_ACK_HOLD: assert property ($rose(sda_d_oe) |-> sda_d_oe[*8])
        else $error("device low too short");
    AST_LOW_TIME: assert property ($fell(scl) |-> !scl[*8])
        else $error("scl low too short");
    AST_HIGH_TIME: assert property ($rose(scl) |-> scl[*8])
        else $error("scl high too short");
    AST_START_HOST: assert property
        ($fell(sda) && scl && $past(scl) |-> sda_m_oe)
        else $error("start not made by host");
endmodule // ssp_chk
`default_nettype wire

// >>> verification/sync_serial_port_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port_status_tb;
    logic              clk = 1'b0, nrst = 1'b0, cv = 1'b0, rr = 1'b1;
    logic              pe = 1'b1, sm = 1'b0;
    logic [2:0]        wrv = 3'h0;
    logic [7:0]        wd = 8'h00, cd = 8'h00;
    ssp_pkg::ssp_cmd_t cs = ssp_pkg::CMD_START;
    wire logic         rdy, ack, rxv, rv;
    wire logic [7:0]   st, sa, rxd, rd;
    int                failures = 0, comparisons = 0, n, rsps = 0;
    ssp_link_if ssp_link_if_i ();
    ssp_device ssp_device_i (.i_clock(clk), .i_nrst(nrst), .i_clock_en(1'b1),
        .i_port_enable(pe), .i_spi_mode(sm), .i_clock_polarity_sel(1'b0),
        .i_status_wr(wrv[0]), .i_status_wdata(wd), .i_addr_wr(wrv[1]),
        .i_addr_wdata(wd), .i_tx_wr(wrv[2]), .i_tx_data(wd), .o_status(st),
        .o_slave_address(sa), .o_rx_valid(rxv), .i_rx_ready(rr),
        .o_rx_data(rxd), .link(ssp_link_if_i));
    ssp_host ssp_host_i (.i_clock(clk), .i_nrst(nrst), .i_clock_en(1'b1),
        .i_cmd_valid(cv), .i_cmd(cs), .i_cmd_data(cd), .o_cmd_ready(rdy),
        .o_rsp_valid(rv), .o_rsp_data(rd), .o_rsp_ack(ack),
        .link(ssp_link_if_i));
    ssp_chk ssp_chk_i (.link_clk(ssp_link_if_i.link_clk), .i_nrst(nrst),
        .scl(ssp_link_if_i.scl), .sda(ssp_link_if_i.sda),
        .scl_oe(ssp_link_if_i.scl_oe), .sda_m_oe(ssp_link_if_i.sda_m_oe),
        .sda_d_oe(ssp_link_if_i.sda_d_oe));
    always #10 clk = ~clk;
    always @(posedge clk)
        if (rv === 1'b1)
            rsps++;
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic reg_wr(input int k, input logic [7:0] d);
        wrv[k] = 1'b1;
        wd = d;
        tick(1);
        wrv[k] = 1'b0;
        tick(2);
    endtask
    // Host is idle on entry, so the command is taken at the first edge
    task automatic send(input ssp_pkg::ssp_cmd_t c, input logic [7:0] d);
        cs = c;
        cd = d;
        cv = 1'b1;
        tick(1);
        cv = 1'b0;
        for (n = 0; rdy !== 1'b1 && n < 3000; n++)
            tick(1);
        if (n == 3000)
        begin
            failures++;
            end_sim();
        end
        tick(12);
    endtask
    initial
    begin
        tick(10);
        nrst = 1'b1;
        tick(10);
        chk(st, 8'h00);
        chk(sa, 8'h00);
        reg_wr(0, 8'hC0);
        chk(8'(st[7:6]), 8'h03);
        reg_wr(0, 8'h00);
        chk(8'(st[7:6]), 8'h00);
        $display("register test done");
        send(ssp_pkg::CMD_START, 8'h00);
        chk(8'(st[5:1]), 8'h04);
        send(ssp_pkg::CMD_WRITE, 8'h02);
        chk(8'(ack), 8'h00);
        send(ssp_pkg::CMD_START, 8'h00);
        reg_wr(1, 8'hA4);
        send(ssp_pkg::CMD_WRITE, 8'hA4);
        chk(8'({ack, st[5:1]}), 8'h25);
        reg_wr(1, 8'hA4);
        chk(8'(st[1]), 8'h00);
        rr = 1'b0;
        send(ssp_pkg::CMD_WRITE, 8'h3C);
        chk(8'({st[5], rxv, st[0]}), 8'h07);
        chk(rxd, 8'h3C);
        rr = 1'b1;
        tick(3);
        chk(8'(st[0]), 8'h00);
        $display("write test done");
        reg_wr(2, 8'h96);
        chk(8'(st[0]), 8'h01);
        send(ssp_pkg::CMD_START, 8'h00);
        chk(8'(st[4:2]), 8'h02);
        send(ssp_pkg::CMD_WRITE, 8'hA5);
        chk(8'({ack, st[2]}), 8'h03);
        send(ssp_pkg::CMD_READ_NACK, 8'h00);
        chk(rd, 8'h96);
        chk(8'(st[0]), 8'h00);
        send(ssp_pkg::CMD_STOP, 8'h00);
        chk(8'(st[4:2]), 8'h04);
        pe = 1'b0;
        tick(12);
        chk(8'(st[4:3]), 8'h00);
        $display("read test done");
        sm = 1'b1;
        pe = 1'b1;
        rr = 1'b0;
        tick(12);
        send(ssp_pkg::CMD_SPI, 8'h5A);
        chk(8'(st[0]), 8'h01);
        chk(rxd, 8'h5A);
        chk(8'(rsps), 8'h06);
        $display("spi test done");
        end_sim();
    end
endmodule // sync_serial_port_status_tb
`default_nettype wire
